// ==== src/usbdp_port_cfg.sv ====
// Purpose: Upstream port control, addressing, buffer layout, endpoint 0 flags
// Assumes: Engine token/transfer strobes on the same clock; pins are async
// Notes:   Register reads return data the cycle after the read strobe
//
// Functional notes
// [R01] Override code 000: engine alone drives the upstream transceiver.
// [R02] Codes 001/010/011 force J, K and single-ended zero.
// [R03] 100 both low, 101 D+ float D- low, 110 reverse, 111 float.
// [R04] Firmware keeps override bits zero for normal USB operation.
// [R05] Any non-idle upstream event sets sticky activity bit 3.
// [R06] Writing 0 clears activity bit; writing 1 keeps it.
// [R07] Bits 5 and 4 read D+ and D- pin levels.
// [R08] Reset clears function address and its enable bit.
// [R09] No response to programmed address until enable bit 7 set.
// [R10] Firmware writes the host-assigned address into bits 6..0.
// [R11] Port bits 7 and 6 pick buffer size and endpoint count.
// [R12] Layout 00: endpoints 0..2 at F8, F0, E8, eight bytes each.
// [R13] Layout 10: ep0 8 bytes at B8, ep1/ep2 32 bytes at C0/E0.
// [R14] Layout 01 five small endpoints; 11 adds ep3/ep4 at A8/B0.
// [R15] Unused buffer areas stay firmware memory, untouched by engine.
// [R16] Each engine buffer byte stalls the processor three cycles.
// [R17] Endpoint 0 is bidirectional incl. setup; others one direction.
// [R18] Endpoint 0 mode register clears to zero on reset.
// [R19] Low four mode bits select endpoint 0 bus response.
// [R20] Transaction ending with acknowledge sets bit 4.
// [R21] OUT token to endpoint 0 sets bit 5; firmware clears.
// [R22] IN token to endpoint 0 sets bit 6; firmware clears.
// [R23] Setup bit set only by engine; any processor write clears it; here a write during a setup token or its data phase leaves it set.
// [R24] After engine update, bits 6..0 locked until processor reads.
// [R25] Accept token only on matching address with enable set.
// [R26] Mode-to-response encoding is a parameter table.
//
// Local design decision: the strobed register port.
module usbdp_port_cfg #(
	parameter logic [31:0] MODE_RESP = 32'h0000_0000
) (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdData,
	input  wire logic       dpPin,
	input  wire logic       dmPin,
	input  wire logic       sieDp,
	input  wire logic       sieDm,
	input  wire logic       sieOe,
	output logic            dpOut,
	output logic            dpOe,
	output logic            dmOut,
	output logic            dmOe,
	input  wire logic       tokValid,
	input  wire logic [1:0] tokType,
	input  wire logic [6:0] tokAddr,
	input  wire logic [3:0] tokEndp,
	output logic            tokAccept,
	input  wire logic       txnEnd,
	input  wire logic       txnAcked,
	output logic      [1:0] ep0Resp,
	input  wire logic       fifoWr,
	input  wire logic [2:0] fifoEp,
	input  wire logic [4:0] fifoOfs,
	input  wire logic [7:0] fifoData,
	output logic            memWe,
	output logic      [7:0] memAddr,
	output logic      [7:0] memData,
	output logic            cpuStall
);
	logic       dpS1_q, dpS2_q, dmS1_q, dmS2_q;
	logic [1:0] layout_q;
	logic [2:0] ovr_q;
	logic       act_q;
	logic [7:0] funcAddr_q;
	logic [3:0] ep0Mode_q;
	logic       ep0Ack_q, ep0Out_q, ep0In_q, ep0Setup_q, lock_q;
	logic [1:0] txnType_q;
	logic [1:0] stallCnt_q;
	usbdp_pkg::usbdp_txn_t txn_q;

	// Register port decode
	wire wrFunc = regWr && (regAddr == usbdp_pkg::ADDR_FUNC);
	wire wrEp0  = regWr && (regAddr == usbdp_pkg::ADDR_EP0);
	wire wrPort = regWr && (regAddr == usbdp_pkg::ADDR_PORT);
	wire rdEp0  = regRd && (regAddr == usbdp_pkg::ADDR_EP0);

	wire [7:0] portVal = {layout_q, dpS2_q, dmS2_q, act_q, ovr_q}; // R07 R11
	wire [7:0] ep0Val  = {ep0Setup_q, ep0In_q, ep0Out_q, ep0Ack_q, ep0Mode_q};
	wire [7:0] rdMux   =
		(regAddr == usbdp_pkg::ADDR_FUNC) ? funcAddr_q :
		(regAddr == usbdp_pkg::ADDR_EP0)  ? ep0Val :
		(regAddr == usbdp_pkg::ADDR_PORT) ? portVal : usbdp_pkg::REG_RESET;

	// Bus activity: anything other than idle J on the synced pair
	wire lineBusy = !(dpS2_q && !dmS2_q); // R05

	// Token acceptance
	wire funcEn  = funcAddr_q[usbdp_pkg::FUNC_EN];
	wire accept  = tokValid && funcEn && (tokAddr == funcAddr_q[6:0]); // R09 R25
	wire ep0Tok  = accept && (tokEndp == 4'h0) && (txn_q == usbdp_pkg::TXN_IDLE);
	wire setSetup = ep0Tok && (tokType == usbdp_pkg::TOK_SETUP);
	wire txnDone = txnEnd && (txn_q == usbdp_pkg::TXN_BUSY);
	// Setup bit held high through the setup data phase
	wire setupHold = (txn_q == usbdp_pkg::TXN_BUSY)
		&& (txnType_q == usbdp_pkg::TOK_SETUP);
	wire cpuLowWr = wrEp0 && !lock_q && !txnDone; // R24

	// Buffer layout map
	logic       epUsed;
	logic [7:0] epBase;
	logic [5:0] epSize;
	always_comb begin
		epUsed = 1'b1;
		epBase = usbdp_pkg::SB_EP0;
		epSize = layout_q[1] ? usbdp_pkg::SIZE_LARGE : usbdp_pkg::SIZE_SMALL; // R11
		case (fifoEp)
			3'h0: begin
				epBase = layout_q[1] ? usbdp_pkg::LB_EP0 : usbdp_pkg::SB_EP0; // R12 R13
				epSize = usbdp_pkg::SIZE_SMALL;
			end
			3'h1: epBase = layout_q[1] ? usbdp_pkg::LB_EP1 : usbdp_pkg::SB_EP1; // R13
			3'h2: epBase = layout_q[1] ? usbdp_pkg::LB_EP2 : usbdp_pkg::SB_EP2; // R12
			3'h3: begin
				epUsed = layout_q[0]; // R14
				epBase = layout_q[1] ? usbdp_pkg::LB_EP3 : usbdp_pkg::SB_EP3;
				epSize = usbdp_pkg::SIZE_SMALL;
			end
			3'h4: begin
				epUsed = layout_q[0]; // R14
				epBase = layout_q[1] ? usbdp_pkg::LB_EP4 : usbdp_pkg::SB_EP4;
				epSize = usbdp_pkg::SIZE_SMALL;
			end
			default: epUsed = 1'b0;
		endcase
	end

	// Writes outside the live layout never reach memory
	wire fifoTake = fifoWr && (stallCnt_q == 2'h0) && epUsed
		&& ({1'b0, fifoOfs} < epSize); // R15
	wire [1:0] stallCnt_d = fifoTake ? usbdp_pkg::STALL_CYCLES :
		(stallCnt_q != 2'h0) ? stallCnt_q - 2'h1 : 2'h0; // R16

	// Line override decode
	logic dpD, dpOeD, dmD, dmOeD;
	always_comb begin
		dpD   = 1'b0;
		dmD   = 1'b0;
		dpOeD = 1'b1;
		dmOeD = 1'b1;
		case (ovr_q)
			usbdp_pkg::OVR_NONE: begin // R01
				dpD   = sieDp;
				dmD   = sieDm;
				dpOeD = sieOe;
				dmOeD = sieOe;
			end
			usbdp_pkg::OVR_J: dpD = 1'b1; // R02
			usbdp_pkg::OVR_K: dmD = 1'b1; // R02
			usbdp_pkg::OVR_SE0: dpD = 1'b0; // R02
			usbdp_pkg::OVR_LOW: dpD = 1'b0; // R03
			usbdp_pkg::OVR_DMLO: dpOeD = 1'b0; // R03
			usbdp_pkg::OVR_DPLO: dmOeD = 1'b0; // R03
			default: begin // R03
				dpOeD = 1'b0;
				dmOeD = 1'b0;
			end
		endcase
	end

	// Pin synchronisers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			// Idle J on reset, else the first edges read as bus activity
			{dpS1_q, dpS2_q} <= 2'h3;
			{dmS1_q, dmS2_q} <= 2'h0;
		end else begin
			dpS1_q <= dpPin;
			dpS2_q <= dpS1_q;
			dmS1_q <= dmPin;
			dmS2_q <= dmS1_q;
		end
	end

	// Port status/control and function address
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			layout_q   <= 2'h0;
			ovr_q      <= usbdp_pkg::OVR_NONE;
			act_q      <= 1'b0;
			funcAddr_q <= usbdp_pkg::REG_RESET; // R08
		end else begin
			if (wrPort) begin
				layout_q <= regWrData[usbdp_pkg::PORT_SIZE:usbdp_pkg::PORT_CNT]; // R11
				ovr_q    <= regWrData[2:0];
			end
			// Bus activity set wins over a same-cycle clear
			if (lineBusy) begin
				act_q <= 1'b1; // R05
			end else if (wrPort && !regWrData[usbdp_pkg::PORT_ACT]) begin
				act_q <= 1'b0; // R06
			end
			if (wrFunc) begin
				funcAddr_q <= regWrData;
			end
		end
	end

	// Endpoint 0 mode register and transaction tracking
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ep0Mode_q  <= 4'h0; // R18
			ep0Ack_q   <= 1'b0;
			ep0Out_q   <= 1'b0;
			ep0In_q    <= 1'b0;
			ep0Setup_q <= 1'b0;
			lock_q     <= 1'b0;
			txn_q      <= usbdp_pkg::TXN_IDLE;
			txnType_q  <= usbdp_pkg::TOK_OUT;
		end else begin
			case (txn_q)
				usbdp_pkg::TXN_IDLE: if (ep0Tok) begin // R17
					txn_q     <= usbdp_pkg::TXN_BUSY;
					txnType_q <= tokType;
				end
				default: if (txnEnd) begin
					txn_q <= usbdp_pkg::TXN_IDLE;
				end
			endcase
			if (setSetup || setupHold) begin
				ep0Setup_q <= 1'b1;
			end else if (wrEp0) begin
				ep0Setup_q <= 1'b0; // R23
			end
			if (txnDone) begin
				ep0Out_q <= ep0Out_q || (txnType_q == usbdp_pkg::TOK_OUT); // R21
				ep0In_q  <= ep0In_q || (txnType_q == usbdp_pkg::TOK_IN); // R22
				ep0Ack_q <= ep0Ack_q || txnAcked; // R20
			end else if (cpuLowWr) begin
				ep0Mode_q <= regWrData[3:0]; // R19
				ep0Ack_q  <= regWrData[usbdp_pkg::EP0_ACK];
				ep0Out_q  <= regWrData[usbdp_pkg::EP0_OUT];
				ep0In_q   <= regWrData[usbdp_pkg::EP0_IN];
			end
			// Engine update re-locks even if read lands the same cycle
			if (txnDone) begin
				lock_q <= 1'b1; // R24
			end else if (rdEp0) begin
				lock_q <= 1'b0; // R24
			end
		end
	end

	// Registered outputs
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData  <= 8'h00;
			{dpOut, dmOut, dpOe, dmOe} <= 4'h0;
			tokAccept  <= 1'b0;
			ep0Resp    <= 2'h0;
			memWe      <= 1'b0;
			memAddr    <= 8'h00;
			memData    <= 8'h00;
			cpuStall   <= 1'b0;
			stallCnt_q <= 2'h0;
		end else begin
			regRdData  <= regRd ? rdMux : 8'h00;
			dpOut      <= dpD;
			dmOut      <= dmD;
			dpOe       <= dpOeD;
			dmOe       <= dmOeD;
			tokAccept  <= accept;
			ep0Resp    <= MODE_RESP[{ep0Mode_q, 1'b0} +: 2]; // R26
			memWe      <= fifoTake;
			memAddr    <= epBase + {3'h0, fifoOfs};
			memData    <= fifoData;
			stallCnt_q <= stallCnt_d;
			cpuStall   <= (stallCnt_d != 2'h0); // R16
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_ovr_none;
		(ovr_q == usbdp_pkg::OVR_NONE) |=> (dpOe == $past(sieOe)) && (dpOut == $past(sieDp));
	endproperty
	a_ovr_none: assert property (p_ovr_none) else $error("engine drive not passed"); // R01

	property p_ovr_se0;
		(ovr_q == usbdp_pkg::OVR_SE0) |=> dpOe && dmOe && !dpOut && !dmOut;
	endproperty
	a_ovr_se0: assert property (p_ovr_se0) else $error("SE0 force wrong"); // R02

	property p_ovr_half;
		(ovr_q == usbdp_pkg::OVR_DMLO) |=> !dpOe && dmOe && !dmOut;
	endproperty
	a_ovr_half: assert property (p_ovr_half) else $error("D+ float force wrong"); // R03

	property p_act_set;
		(lineBusy || (act_q && !(wrPort && !regWrData[usbdp_pkg::PORT_ACT]))) |=> act_q;
	endproperty
	a_act_set: assert property (p_act_set) else $error("activity not sticky"); // R05

	property p_act_clr;
		(wrPort && !regWrData[usbdp_pkg::PORT_ACT] && !lineBusy) |=> !act_q;
	endproperty
	a_act_clr: assert property (p_act_clr) else $error("activity not cleared"); // R06

	property p_pin_read;
		(regRd && regAddr == usbdp_pkg::ADDR_PORT) |=>
			(regRdData[usbdp_pkg::PORT_DP] == $past(dpS2_q))
			&& (regRdData[usbdp_pkg::PORT_DM] == $past(dmS2_q));
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin readback wrong"); // R07

	property p_addr_gate;
		(tokValid && (!funcEn || tokAddr != funcAddr_q[6:0])) |=> !tokAccept;
	endproperty
	a_addr_gate: assert property (p_addr_gate) else $error("foreign token taken"); // R09

	sequence s_take;
		fifoTake;
	endsequence
	sequence s_stall3;
		cpuStall [*3] ##1 !cpuStall;
	endsequence
	property p_stall;
		s_take |=> s_stall3;
	endproperty
	a_stall: assert property (p_stall) else $error("stall length wrong"); // R16

	property p_unused;
		(fifoWr && !epUsed) |=> !memWe;
	endproperty
	a_unused: assert property (p_unused) else $error("unused area written"); // R15

	property p_setup_clr;
		(wrEp0 && !setSetup && !setupHold) |=> !ep0Setup_q;
	endproperty
	a_setup_clr: assert property (p_setup_clr) else $error("setup not cleared"); // R23

	property p_lock;
		(lock_q && wrEp0 && !txnDone && !rdEp0) |=> $stable(ep0Val[6:0]);
	endproperty
	a_lock: assert property (p_lock) else $error("locked bits written"); // R24

	property p_ack;
		(txnDone && txnAcked) |=> ep0Ack_q && lock_q;
	endproperty
	a_ack: assert property (p_ack) else $error("ack flag missing"); // R20

	property p_ovr_j;
		(ovr_q == usbdp_pkg::OVR_J) |=> dpOe && dmOe && dpOut && !dmOut;
	endproperty
	a_ovr_j: assert property (p_ovr_j) else $error("J force wrong"); // R02

	property p_ovr_float;
		(ovr_q == usbdp_pkg::OVR_FLOAT) |=> !dpOe && !dmOe;
	endproperty
	a_ovr_float: assert property (p_ovr_float) else $error("float force wrong"); // R03

	property p_setup_set;
		setSetup |=> ep0Setup_q;
	endproperty
	a_setup_set: assert property (p_setup_set) else $error("setup flag missing"); // R23

	property p_out_flag;
		(txnDone && txnType_q == usbdp_pkg::TOK_OUT) |=> ep0Out_q && lock_q;
	endproperty
	a_out_flag: assert property (p_out_flag) else $error("out flag missing"); // R21

	property p_in_flag;
		(txnDone && txnType_q == usbdp_pkg::TOK_IN) |=> ep0In_q && lock_q;
	endproperty
	a_in_flag: assert property (p_in_flag) else $error("in flag missing"); // R22

	property p_unlock;
		(rdEp0 && !txnDone) |=> !lock_q;
	endproperty
	a_unlock: assert property (p_unlock) else $error("read did not unlock"); // R24
endmodule : usbdp_port_cfg

// ==== pkg/usbdp_pkg.sv ====
// Purpose: Shared constants for the upstream port configuration block
// Assumes: 8-bit register port, single system clock
// Notes:   Offsets are byte addresses on the register port
package usbdp_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_FUNC = 8'h10;
	localparam logic [7:0] ADDR_EP0  = 8'h12;
	localparam logic [7:0] ADDR_PORT = 8'h1F;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Port status/control fields
	localparam int PORT_SIZE = 7;
	localparam int PORT_CNT  = 6;
	localparam int PORT_DP   = 5;
	localparam int PORT_DM   = 4;
	localparam int PORT_ACT  = 3;

	// Endpoint 0 mode fields
	localparam int EP0_SETUP = 7;
	localparam int EP0_IN    = 6;
	localparam int EP0_OUT   = 5;
	localparam int EP0_ACK   = 4;

	// Function address enable
	localparam int FUNC_EN = 7;

	// Line override codes
	localparam logic [2:0] OVR_NONE  = 3'h0;
	localparam logic [2:0] OVR_J     = 3'h1;
	localparam logic [2:0] OVR_K     = 3'h2;
	localparam logic [2:0] OVR_SE0   = 3'h3;
	localparam logic [2:0] OVR_LOW   = 3'h4;
	localparam logic [2:0] OVR_DMLO  = 3'h5;
	localparam logic [2:0] OVR_DPLO  = 3'h6;
	localparam logic [2:0] OVR_FLOAT = 3'h7;

	// Endpoint buffer bases, small (8-byte) and large layouts
	localparam logic [7:0] SB_EP0 = 8'hF8;
	localparam logic [7:0] SB_EP1 = 8'hF0;
	localparam logic [7:0] SB_EP2 = 8'hE8;
	localparam logic [7:0] SB_EP3 = 8'hE0;
	localparam logic [7:0] SB_EP4 = 8'hD8;
	localparam logic [7:0] LB_EP0 = 8'hB8;
	localparam logic [7:0] LB_EP1 = 8'hC0;
	localparam logic [7:0] LB_EP2 = 8'hE0;
	localparam logic [7:0] LB_EP3 = 8'hA8;
	localparam logic [7:0] LB_EP4 = 8'hB0;
	localparam logic [5:0] SIZE_SMALL = 6'h08;
	localparam logic [5:0] SIZE_LARGE = 6'h20;

	// Processor stall per engine byte
	localparam logic [1:0] STALL_CYCLES = 2'h3;

	typedef enum logic [1:0] {
		TOK_OUT   = 2'h0,
		TOK_IN    = 2'h1,
		TOK_SETUP = 2'h3
	} usbdp_tok_t;

	// Gray-coded endpoint 0 transaction tracker
	typedef enum logic [1:0] {
		TXN_IDLE = 2'h0,
		TXN_BUSY = 2'h1
	} usbdp_txn_t;
endpackage : usbdp_pkg

// ==== verification/usbdp_host_model.sv ====
// Purpose: Upstream bus model, host side of the D+/D- pair
// Assumes: Device drive wins while its enable is high
// Notes:   Released lines settle to the full-speed pull levels (J)
module usbdp_host_model (
	input  wire logic dpOut,
	input  wire logic dpOe,
	input  wire logic dmOut,
	input  wire logic dmOe,
	input  wire logic hostDrv,
	input  wire logic hostDp,
	input  wire logic hostDm,
	output logic      dpPin,
	output logic      dmPin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-up on D+, pull-down on D-, so an undriven pair reads idle
	assign dpPin = dpOe ? dpOut : (hostDrv ? hostDp : 1'b1);
	assign dmPin = dmOe ? dmOut : (hostDrv ? hostDm : 1'b0);
endmodule : usbdp_host_model

// ==== verification/usbdp_tb.sv ====
// Purpose: Self-checking bench for the upstream port configuration block
// Assumes: Register port answers one cycle after the read strobe
// Notes:   Mode response table set to a known pattern for checking
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock, sys_rst, regWr, regRd, sieDp, sieDm, sieOe, tokValid;
	logic       txnEnd, txnAcked, fifoWr, dpPin, dmPin, dpOut, dpOe, dmOut, dmOe;
	logic       tokAccept, memWe, cpuStall, hostDrv, hostDp, hostDm;
	logic [7:0] regAddr, regWrData, regRdData, fifoData, memAddr, memData;
	logic [1:0] tokType, ep0Resp;
	logic [6:0] tokAddr;
	logic [3:0] tokEndp;
	logic [2:0] fifoEp;
	logic [4:0] fifoOfs;
	int         n_mismatch = 0;
	int         cmp_count = 0;
	// Per code: {dpOe, dp driven, dmOe, dm driven}, sie drives K for code 000
	localparam logic [31:0] OVR_TBL = 32'h082A_ABEB;

	usbdp_port_cfg #(.MODE_RESP(32'h0000_00E4)) i_usbdp_port_cfg (
		.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dpPin(dpPin),
		.dmPin(dmPin), .sieDp(sieDp), .sieDm(sieDm), .sieOe(sieOe), .dpOut(dpOut),
		.dpOe(dpOe), .dmOut(dmOut), .dmOe(dmOe), .tokValid(tokValid),
		.tokType(tokType), .tokAddr(tokAddr), .tokEndp(tokEndp),
		.tokAccept(tokAccept), .txnEnd(txnEnd), .txnAcked(txnAcked),
		.ep0Resp(ep0Resp), .fifoWr(fifoWr), .fifoEp(fifoEp), .fifoOfs(fifoOfs),
		.fifoData(fifoData), .memWe(memWe), .memAddr(memAddr), .memData(memData),
		.cpuStall(cpuStall));

	usbdp_host_model i_usbdp_host_model (
		.dpOut(dpOut), .dpOe(dpOe), .dmOut(dmOut), .dmOe(dmOe), .hostDrv(hostDrv),
		.hostDp(hostDp), .hostDm(hostDm), .dpPin(dpPin), .dmPin(dmPin));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic print_verdict();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask : wr

	// Data must stand for exactly one cycle, then fall back to zero
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), exp, regRdData);
		@(posedge clock);
		#1;
		chk("regRdData idle", 8'h00, regRdData);
	endtask : rdchk

	task automatic tok(input logic [1:0] t, input logic [6:0] a, input logic [3:0] e,
		input logic exp);
		@(posedge clock);
		tokValid <= 1'b1;
		tokType <= t;
		tokAddr <= a;
		tokEndp <= e;
		@(posedge clock);
		tokValid <= 1'b0;
		#1;
		chk("tokAccept", {7'h0, exp}, {7'h0, tokAccept});
	endtask : tok

	task automatic txn(input logic ack);
		@(posedge clock);
		txnEnd <= 1'b1;
		txnAcked <= ack;
		@(posedge clock);
		txnEnd <= 1'b0;
		txnAcked <= 1'b0;
		@(posedge clock);
	endtask : txn

	task automatic fifo(input logic [2:0] ep, input logic [4:0] ofs, input logic [7:0] a,
		input logic ok);
		@(posedge clock);
		fifoWr <= 1'b1;
		fifoEp <= ep;
		fifoOfs <= ofs;
		fifoData <= a ^ 8'h5A;
		@(posedge clock);
		fifoWr <= 1'b0;
		#1;
		chk("memWe", {7'h0, ok}, {7'h0, memWe});
		if (ok) begin
			chk("memAddr", a, memAddr);
			chk("memData", a ^ 8'h5A, memData);
		end
		for (int i = 0; i < 4; i++) begin
			chk("cpuStall", {7'h0, ok && i < 3}, {7'h0, cpuStall});
			@(posedge clock);
			#1;
		end
	endtask : fifo

	task automatic t_reset();
		rdchk(8'h10, 8'h00);
		rdchk(8'h12, 8'h00);
		rdchk(8'h1F, 8'h20);
		wr(8'h11, 8'hFF);
		rdchk(8'h11, 8'h00);
	endtask : t_reset

	task automatic t_override();
		@(posedge clock);
		sieOe <= 1'b1;
		sieDm <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(8'h1F, 8'(c));
			@(posedge clock);
			#1;
			chk("pins", {4'h0, OVR_TBL[4*c +: 4]},
				{4'h0, dpOe, dpOe & dpOut, dmOe, dmOe & dmOut});
		end
		wr(8'h1F, 8'h00);
		sieOe <= 1'b0;
	endtask : t_override

	task automatic t_activity();
		repeat (4) @(posedge clock);
		wr(8'h1F, 8'h00);
		rdchk(8'h1F, 8'h20);
		hostDrv <= 1'b1;
		repeat (4) @(posedge clock);
		rdchk(8'h1F, 8'h08);
		hostDrv <= 1'b0;
		repeat (4) @(posedge clock);
		wr(8'h1F, 8'h08);
		rdchk(8'h1F, 8'h28);
		wr(8'h1F, 8'h00);
		rdchk(8'h1F, 8'h20);
	endtask : t_activity

	task automatic t_token();
		tok(2'h3, 7'h00, 4'h0, 1'b0);
		wr(8'h10, 8'h85);
		rdchk(8'h10, 8'h85);
		tok(2'h0, 7'h06, 4'h1, 1'b0);
		tok(2'h0, 7'h05, 4'h1, 1'b1);
		rdchk(8'h12, 8'h00);
	endtask : t_token

	task automatic t_ep0();
		tok(2'h3, 7'h05, 4'h0, 1'b1);
		rdchk(8'h12, 8'h80);
		txn(1'b1);
		wr(8'h12, 8'h0F);
		rdchk(8'h12, 8'h10);
		wr(8'h12, 8'h02);
		rdchk(8'h12, 8'h02);
		chk("ep0Resp", 8'h02, {6'h0, ep0Resp});
		tok(2'h0, 7'h05, 4'h0, 1'b1);
		txn(1'b0);
		rdchk(8'h12, 8'h22);
		wr(8'h12, 8'h00);
		tok(2'h1, 7'h05, 4'h0, 1'b1);
		txn(1'b1);
		rdchk(8'h12, 8'h50);
	endtask : t_ep0

	task automatic t_fifo();
		wr(8'h1F, 8'h00);
		fifo(3'h0, 5'h00, 8'hF8, 1'b1);
		fifo(3'h2, 5'h07, 8'hEF, 1'b1);
		fifo(3'h3, 5'h00, 8'h00, 1'b0);
		fifo(3'h1, 5'h08, 8'h00, 1'b0);
		wr(8'h1F, 8'h40);
		fifo(3'h3, 5'h01, 8'hE1, 1'b1);
		fifo(3'h4, 5'h07, 8'hDF, 1'b1);
		wr(8'h1F, 8'h80);
		fifo(3'h0, 5'h07, 8'hBF, 1'b1);
		fifo(3'h1, 5'h1F, 8'hDF, 1'b1);
		fifo(3'h2, 5'h00, 8'hE0, 1'b1);
		fifo(3'h3, 5'h00, 8'h00, 1'b0);
		fifo(3'h0, 5'h08, 8'h00, 1'b0);
		fifo(3'h5, 5'h00, 8'h00, 1'b0);
		wr(8'h1F, 8'hC0);
		fifo(3'h3, 5'h00, 8'hA8, 1'b1);
		fifo(3'h4, 5'h02, 8'hB2, 1'b1);
	endtask : t_fifo

	// Whole run is well under a thousand cycles
	initial begin
		#2000000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		{regWr, regRd, sieDp, sieDm, sieOe, tokValid, txnEnd, txnAcked, fifoWr} = '0;
		{hostDrv, hostDp, hostDm} = '0;
		{regAddr, regWrData, fifoData, tokType, tokAddr, tokEndp, fifoEp, fifoOfs} = '0;
		sys_rst = 1'b1;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_override();
		t_activity();
		t_token();
		t_ep0();
		t_fifo();
		print_verdict();
	end
endmodule : testbench
